// [sdct_ctrl.sv]
`default_nettype none
module sdct_ctrl #(
  parameter int unsigned ROW_W    = 13,
  parameter int unsigned COL_W    = 9,
  parameter int unsigned DATA_W   = 16,
  parameter int unsigned REFI_CYC = sdct_pkg::REFI_CYC
) (
  input  wire logic                    clk_in,          // system clock
  input  wire logic                    rst_n_in,        // sync reset
  input  wire logic                    req_valid_in,    // access request
  output logic                         req_ready_out,   // request taken
  input  wire logic                    req_write_in,    // 1 write, 0 read
  input  wire logic [1:0]              req_bank_in,     // bank
  input  wire logic [ROW_W-1:0]        req_row_in,      // row
  input  wire logic [COL_W-1:0]        req_col_in,      // column
  input  wire logic [DATA_W-1:0]       req_wdata_in,    // write word
  input  wire logic [DATA_W/8-1:0]     req_mask_in,     // byte masks
  input  wire logic [1:0]              rcd_field_in,    // row-to-column field
  input  wire logic                    cas_latency_field_in, // 0 two, 1 three
  input  wire logic [ROW_W-1:0]        mode_opcode_in,  // mode opcode
  input  wire logic [ROW_W-1:0]        ext_opcode_in,   // extended opcode
  output logic                         rd_valid_out,    // read word
  input  wire logic                    rd_ready_in,     // consumer ready
  output logic [DATA_W-1:0]            rd_data_out,     // read data
  output logic                         init_done_out,   // init complete
  output logic                         forwarded_out_clock_out, // memory clock
  input  wire logic                    ret_clock_in,    // returned clock
  output logic                         mem_chip_select_n_out, // select
  output logic                         row_strobe_n_out, // row strobe
  output logic                         column_strobe_n_out, // column strobe
  output logic                         write_enable_n_out, // write enable
  output logic [DATA_W/8-1:0]          byte_lane_mask_out, // byte masks
  output logic [ROW_W+1:0]             addr_out,        // bank bits on top
  input  wire logic [DATA_W-1:0]       dq_in,           // data pins in
  output logic [DATA_W-1:0]            dq_out,          // data pins out
  output logic                         dq_oe_out        // drive data pins
);
  localparam int unsigned MW = DATA_W / 8;
  localparam int unsigned AW = ROW_W + 2;

  initial begin
    if (ROW_W < 11 || COL_W > 10 || COL_W < 1 || (DATA_W % 8) != 0 || REFI_CYC < 64) begin
      $error("sdct_ctrl: unsupported parameters");
    end
  end

  sdct_pkg::sdct_state_t st_q;
  logic [15:0]           wait_q;
  sdct_pkg::sdct_state_t after_q;
  logic [3:0]            cmd_q;
  logic [AW-1:0]         addr_q;
  logic [MW-1:0]         mask_q;
  logic [DATA_W-1:0]     dq_q;
  logic                  dq_oe_q;
  logic                  is_wr_q;
  logic [1:0]            bank_q;
  logic [COL_W-1:0]      col_q;
  logic [DATA_W-1:0]     wdata_q;
  logic [MW-1:0]         wmask_q;
  logic [15:0]           refi_q;
  logic                  ref_due_q;
  logic                  init_q;
  logic                  fclk_q;
  logic                  take;
  logic [15:0]           rcd_cyc;
  logic [3:0]            rd_pipe_q;
  logic [1:0]            rclk_sync_q;
  logic                  rclk_prev_q;
  logic [DATA_W-1:0]     dq_s1_q;
  logic [DATA_W-1:0]     dq_s2_q;
  logic                  cap_valid_q;
  logic [DATA_W-1:0]     cap_data_q;
  logic                  buf_ready;

  // memory clock: one flip at every rising edge, half the system rate
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fclk_q <= 1'b0;
    end else begin
      fclk_q <= ~fclk_q;
    end
  end
  assign forwarded_out_clock_out = fclk_q;

  // returned clock and data pass two flops before use
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rclk_sync_q <= 2'h0;
      rclk_prev_q <= 1'b0;
      dq_s1_q     <= '0;
      dq_s2_q     <= '0;
    end else begin
      rclk_sync_q <= {rclk_sync_q[0], ret_clock_in};
      rclk_prev_q <= rclk_sync_q[1];
      dq_s1_q     <= dq_in;
      dq_s2_q     <= dq_s1_q;
    end
  end

  // write takes the field plus one extra cycle
  assign rcd_cyc = 16'(sdct_pkg::RCD_MIN_CYC) + {14'h0, rcd_field_in}
                 + {15'h0, req_write_in};

  assign take = (st_q == sdct_pkg::ST_IDLE) && req_valid_in && !ref_due_q && buf_ready;
  assign req_ready_out = take;

  // refresh interval; a pending refresh beats new requests
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      refi_q    <= 16'h0;
      ref_due_q <= 1'b0;
    end else begin
      if (!init_q || refi_q == 16'(REFI_CYC - 1)) begin
        refi_q <= 16'h0;
      end else begin
        refi_q <= refi_q + 16'h1;
      end
      if (init_q && refi_q == 16'(REFI_CYC - 1)) begin
        ref_due_q <= 1'b1;
      end else if (st_q == sdct_pkg::ST_REF) begin
        ref_due_q <= 1'b0;
      end
    end
  end

  // command sequencer
  // a wait count of n puts the next command n+2 cycles after this one,
  // so every load below is the cycle figure minus two; a larger load
  // would stretch row-to-column past its upper bound
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_q    <= sdct_pkg::ST_INIT_PRE;
      after_q <= sdct_pkg::ST_IDLE;
      wait_q  <= 16'h0;
      cmd_q   <= sdct_pkg::CMD_INHIBIT;
      addr_q  <= '0;
      mask_q  <= '1;
      dq_q    <= '0;
      dq_oe_q <= 1'b0;
      is_wr_q <= 1'b0;
      bank_q  <= 2'h0;
      col_q   <= '0;
      wdata_q <= '0;
      wmask_q <= '0;
      init_q  <= 1'b0;
    end else begin
      cmd_q   <= sdct_pkg::CMD_NOP;
      dq_oe_q <= 1'b0;
      mask_q  <= '1;
      case (st_q)
        sdct_pkg::ST_INIT_PRE: begin
          cmd_q  <= sdct_pkg::CMD_PRE;
          addr_q <= AW'(1) << sdct_pkg::A10_POS;
          wait_q <= 16'(sdct_pkg::RP_CYC - 2);
          after_q <= sdct_pkg::ST_INIT_MR;
          st_q   <= sdct_pkg::ST_WAIT;
        end
        sdct_pkg::ST_INIT_MR: begin
          cmd_q  <= sdct_pkg::CMD_LMR;
          addr_q <= {2'h0, mode_opcode_in};
          wait_q <= 16'h0;
          after_q <= sdct_pkg::ST_INIT_EMR;
          st_q   <= sdct_pkg::ST_WAIT;
        end
        sdct_pkg::ST_INIT_EMR: begin
          cmd_q  <= sdct_pkg::CMD_LMR;
          addr_q <= {2'(sdct_pkg::EMR_BA), ext_opcode_in};
          wait_q <= 16'h0;
          after_q <= sdct_pkg::ST_IDLE;
          init_q <= 1'b1;
          st_q   <= sdct_pkg::ST_WAIT;
        end
        sdct_pkg::ST_IDLE: begin
          if (ref_due_q) begin
            st_q <= sdct_pkg::ST_REF;
          end else if (take) begin
            cmd_q   <= sdct_pkg::CMD_ACTIVE;
            addr_q  <= {req_bank_in, req_row_in};
            is_wr_q <= req_write_in;
            bank_q  <= req_bank_in;
            col_q   <= req_col_in;
            wdata_q <= req_wdata_in;
            wmask_q <= req_mask_in;
            wait_q  <= rcd_cyc - 16'h2;
            after_q <= sdct_pkg::ST_COL;
            st_q    <= sdct_pkg::ST_WAIT;
          end
        end
        sdct_pkg::ST_COL: begin
          addr_q <= {bank_q, ROW_W'(col_q)};
          if (is_wr_q) begin
            cmd_q   <= sdct_pkg::CMD_WRITE;
            mask_q  <= wmask_q;
            dq_q    <= wdata_q;
            dq_oe_q <= 1'b1;
            wait_q  <= 16'(sdct_pkg::WR_CYC - 2);
          end else begin
            cmd_q  <= sdct_pkg::CMD_READ;
            mask_q <= '0;
            wait_q <= 16'(sdct_pkg::WR_CYC - 2);
          end
          after_q <= sdct_pkg::ST_PRE;
          st_q    <= sdct_pkg::ST_WAIT;
        end
        sdct_pkg::ST_PRE: begin
          if (is_wr_q || cap_valid_q || rd_pipe_q == 4'h0) begin
            cmd_q  <= sdct_pkg::CMD_PRE;
            addr_q <= {bank_q, ROW_W'(0)};
            wait_q <= 16'(sdct_pkg::RP_CYC - 2);
            after_q <= sdct_pkg::ST_IDLE;
            st_q   <= sdct_pkg::ST_WAIT;
          end
        end
        sdct_pkg::ST_REF: begin
          cmd_q  <= sdct_pkg::CMD_REF;
          wait_q <= 16'(sdct_pkg::RFC_CYC - 2);
          after_q <= sdct_pkg::ST_IDLE;
          st_q   <= sdct_pkg::ST_WAIT;
        end
        sdct_pkg::ST_WAIT: begin
          if (wait_q == 16'h0) begin
            st_q <= after_q;
          end else begin
            wait_q <= wait_q - 16'h1;
          end
        end
        default: begin
          st_q <= sdct_pkg::ST_INIT_PRE;
        end
      endcase
    end
  end

  // read capture: launch cycle, CAS latency and two sync stages, then a returned-clock rise
  // the memory only sees the command one edge after it leaves the pins
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_pipe_q   <= 4'h0;
      cap_valid_q <= 1'b0;
      cap_data_q  <= '0;
    end else begin
      cap_valid_q <= 1'b0;
      if (st_q == sdct_pkg::ST_COL && !is_wr_q) begin
        rd_pipe_q <= 4'(cas_latency_field_in ? sdct_pkg::CL3_CYC : sdct_pkg::CL2_CYC)
                   + 4'h3;
      end else if (rd_pipe_q > 4'h1) begin
        rd_pipe_q <= rd_pipe_q - 4'h1;
      end else if (rd_pipe_q == 4'h1 && rclk_sync_q[1] && !rclk_prev_q) begin
        rd_pipe_q   <= 4'h0;
        cap_valid_q <= 1'b1;
        cap_data_q  <= dq_s2_q;
      end
    end
  end

  // only one read outstanding, so a request waits for buffer room
  sdct_skid #(
    .WIDTH (DATA_W)
  ) u_skid (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .s_valid_in  (cap_valid_q),
    .s_ready_out (buf_ready),
    .s_data_in   (cap_data_q),
    .m_valid_out (rd_valid_out),
    .m_ready_in  (rd_ready_in),
    .m_data_out  (rd_data_out)
  );

  assign mem_chip_select_n_out = cmd_q[3];
  assign row_strobe_n_out      = cmd_q[2];
  assign column_strobe_n_out   = cmd_q[1];
  assign write_enable_n_out    = cmd_q[0];
  assign byte_lane_mask_out    = mask_q;
  assign addr_out              = addr_q;
  assign dq_out                = dq_q;
  assign dq_oe_out             = dq_oe_q;
  assign init_done_out         = init_q;
endmodule
`default_nettype wire

// [sdct_pkg.sv]
`default_nettype none
package sdct_pkg;
  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int unsigned T_RP_PS       = 24000;
  localparam int unsigned T_WR_PS       = 16000;
  localparam int unsigned T_RCD_MIN_PS  = 16000;
  localparam int unsigned T_CAS2_PS     = 16000;
  localparam int unsigned T_CAS3_PS     = 24000;
  localparam int unsigned T_REFI_PS     = 7800000;
  localparam int unsigned T_RFC_PS      = 64000;
  localparam int unsigned T_CK_MIN_PS   = 7900;
  localparam int unsigned T_CK_MAX_PS   = 8100;
  localparam int unsigned RP_CYC   = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WR_CYC   = (T_WR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RFC_CYC  = (T_RFC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned REFI_CYC = T_REFI_PS / CLK_PERIOD_PS;
  localparam int unsigned CL2_CYC  = (T_CAS2_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CL3_CYC  = (T_CAS3_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RCD_MIN_CYC = (T_RCD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CMD_W = 4;
  localparam logic [3:0] CMD_INHIBIT = 4'hF;
  localparam logic [3:0] CMD_NOP     = 4'h7;
  localparam logic [3:0] CMD_ACTIVE  = 4'h3;
  localparam logic [3:0] CMD_READ    = 4'h5;
  localparam logic [3:0] CMD_WRITE   = 4'h4;
  localparam logic [3:0] CMD_BST     = 4'h6;
  localparam logic [3:0] CMD_PRE     = 4'h2;
  localparam logic [3:0] CMD_REF     = 4'h1;
  localparam logic [3:0] CMD_LMR     = 4'h0;
  localparam int unsigned A10_POS    = 10;
  localparam int unsigned EMR_BA     = 2;
  typedef enum logic [3:0] {
    ST_INIT_PRE  = 4'h0,
    ST_INIT_MR   = 4'h1,
    ST_INIT_EMR  = 4'h2,
    ST_IDLE      = 4'h3,
    ST_ACT       = 4'h4,
    ST_RCD       = 4'h5,
    ST_COL       = 4'h6,
    ST_WAIT_DATA = 4'h7,
    ST_RECOVER   = 4'h8,
    ST_PRE       = 4'h9,
    ST_REF       = 4'hA,
    ST_WAIT      = 4'hB
  } sdct_state_t;
endpackage
`default_nettype wire

// [sdct_skid.sv]
`default_nettype none
// two-entry buffer: a receiver stall never drops a captured word
module sdct_skid #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             clk_in,    // system clock
  input  wire logic             rst_n_in,  // sync reset
  input  wire logic             s_valid_in, // word offered
  output logic                  s_ready_out, // room available
  input  wire logic [WIDTH-1:0] s_data_in, // word
  output logic                  m_valid_out, // word held
  input  wire logic             m_ready_in, // receiver takes
  output logic      [WIDTH-1:0] m_data_out // oldest word
);
  logic [WIDTH-1:0] mem_q [2];
  logic             wp_q;
  logic             rp_q;
  logic [1:0]       cnt_q;
  logic             push;
  logic             pop;

  assign s_ready_out = (cnt_q != 2'h2);
  assign m_valid_out = (cnt_q != 2'h0);
  assign m_data_out  = mem_q[rp_q];
  assign push = s_valid_in && s_ready_out;
  assign pop  = m_valid_out && m_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wp_q] <= s_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// [sdct_ctrl_assertions.sv]
`default_nettype none
module sdct_ctrl_checker #(
  parameter int unsigned ROW_W    = 13,
  parameter int unsigned COL_W    = 9,
  parameter int unsigned DATA_W   = 16,
  parameter int unsigned REFI_CYC = 100
) (
  input wire logic                clk_in,        // clock
  input wire logic                rst_n_in,      // reset
  input wire logic                req_valid_in,  // request
  input wire logic                req_ready_out, // taken
  input wire logic                req_write_in,  // write
  input wire logic [1:0]          req_bank_in,   // bank
  input wire logic [ROW_W-1:0]    req_row_in,    // row
  input wire logic [COL_W-1:0]    req_col_in,    // column
  input wire logic [DATA_W-1:0]   req_wdata_in,  // data
  input wire logic [DATA_W/8-1:0] req_mask_in,   // masks
  input wire logic [1:0]          rcd_field_in,  // delay
  input wire logic [ROW_W-1:0]    mode_opcode_in, // opcode
  input wire logic [ROW_W-1:0]    ext_opcode_in, // opcode
  input wire logic                init_done_out, // ready
  input wire logic                forwarded_out_clock_out, // mem clock
  input wire logic                mem_chip_select_n_out, // select
  input wire logic                row_strobe_n_out, // row
  input wire logic                column_strobe_n_out, // column
  input wire logic                write_enable_n_out, // write
  input wire logic [DATA_W/8-1:0] byte_lane_mask_out, // masks
  input wire logic [ROW_W+1:0]    addr_out,      // address
  input wire logic [DATA_W-1:0]   dq_out,        // data
  input wire logic                dq_oe_out      // drive
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [3:0]          cmd;
  logic [3:0]          cnt_q;
  logic [3:0]          exp_q;
  logic [1:0]          bank_q;
  logic [COL_W-1:0]    col_q;
  logic [DATA_W-1:0]   wd_q;
  logic [DATA_W/8-1:0] msk_q;
  logic [15:0]         ref_q;
  assign cmd = {mem_chip_select_n_out, row_strobe_n_out, column_strobe_n_out, write_enable_n_out};
  // the column phase is judged against the request that opened the row
  always_ff @(posedge clk_in) begin
    if (req_valid_in && req_ready_out) begin
      exp_q <= 4'(sdct_pkg::RCD_MIN_CYC) + 4'(rcd_field_in) + 4'(req_write_in);
      bank_q <= req_bank_in;
      col_q <= req_col_in;
      wd_q <= req_wdata_in;
      msk_q <= req_mask_in;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) cnt_q <= 4'hF;
    else if (cmd == sdct_pkg::CMD_ACTIVE) cnt_q <= 4'h1;
    else if (cnt_q != 4'hF) cnt_q <= cnt_q + 4'h1;
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || cmd == sdct_pkg::CMD_REF) ref_q <= 16'h0000;
    else if (ref_q != 16'hFFFF) ref_q <= ref_q + 16'h0001;
  end
  property p_act;
    req_valid_in && req_ready_out |=> cmd == sdct_pkg::CMD_ACTIVE
      && addr_out == {$past(req_bank_in), $past(req_row_in)};
  endproperty
  a_act: assert property (p_act) else $error("activate wrong");
  property p_col_time;
    cmd == sdct_pkg::CMD_READ || cmd == sdct_pkg::CMD_WRITE |-> cnt_q == exp_q;
  endproperty
  a_col_time: assert property (p_col_time) else $error("row to column delay");
  property p_col_addr;
    cmd == sdct_pkg::CMD_READ || cmd == sdct_pkg::CMD_WRITE
      |-> addr_out[ROW_W+1:ROW_W] == bank_q && addr_out[COL_W-1:0] == col_q;
  endproperty
  a_col_addr: assert property (p_col_addr) else $error("column address");
  property p_wr_data;
    cmd == sdct_pkg::CMD_WRITE |-> dq_oe_out && dq_out == wd_q && byte_lane_mask_out == msk_q;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data");
  property p_wr_pre;
    cmd == sdct_pkg::CMD_WRITE |-> ##2 cmd == sdct_pkg::CMD_PRE;
  endproperty
  a_wr_pre: assert property (p_wr_pre) else $error("write recovery");
  property p_rp;
    cmd == sdct_pkg::CMD_PRE |=> (cmd != sdct_pkg::CMD_ACTIVE) [*2];
  endproperty
  a_rp: assert property (p_rp) else $error("precharge wait");
  property p_init_pre;
    $rose(rst_n_in) |=> cmd == sdct_pkg::CMD_PRE && addr_out[sdct_pkg::A10_POS];
  endproperty
  a_init_pre: assert property (p_init_pre) else $error("no precharge all");
  property p_mode;
    cmd == sdct_pkg::CMD_LMR && addr_out[ROW_W+1:ROW_W] != 2'(sdct_pkg::EMR_BA)
      |-> addr_out[ROW_W-1:0] == mode_opcode_in ##[2:3] cmd == sdct_pkg::CMD_LMR
      && addr_out == {2'(sdct_pkg::EMR_BA), ext_opcode_in};
  endproperty
  a_mode: assert property (p_mode) else $error("mode loads");
  property p_act_init;
    cmd == sdct_pkg::CMD_ACTIVE |-> init_done_out;
  endproperty
  a_act_init: assert property (p_act_init) else $error("early activate");
  property p_refresh;
    ref_q < 16'(REFI_CYC + 40);
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh late");
  property p_fclk;
    init_done_out |=> forwarded_out_clock_out != $past(forwarded_out_clock_out);
  endproperty
  a_fclk: assert property (p_fclk) else $error("memory clock stuck");
  c_wr: cover property (cmd == sdct_pkg::CMD_WRITE);
  c_rd: cover property (cmd == sdct_pkg::CMD_READ);
  c_ref: cover property (cmd == sdct_pkg::CMD_REF);
endmodule
bind sdct_ctrl sdct_ctrl_checker #(.ROW_W(ROW_W), .COL_W(COL_W), .DATA_W(DATA_W),
  .REFI_CYC(REFI_CYC)) u_sdct_ctrl_checker (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .req_write_in(req_write_in),
  .req_bank_in(req_bank_in), .req_row_in(req_row_in), .req_col_in(req_col_in),
  .req_wdata_in(req_wdata_in), .req_mask_in(req_mask_in), .rcd_field_in(rcd_field_in),
  .mode_opcode_in(mode_opcode_in), .ext_opcode_in(ext_opcode_in),
  .init_done_out(init_done_out), .forwarded_out_clock_out(forwarded_out_clock_out),
  .mem_chip_select_n_out(mem_chip_select_n_out), .row_strobe_n_out(row_strobe_n_out),
  .column_strobe_n_out(column_strobe_n_out), .write_enable_n_out(write_enable_n_out),
  .byte_lane_mask_out(byte_lane_mask_out), .addr_out(addr_out), .dq_out(dq_out),
  .dq_oe_out(dq_oe_out));
`default_nettype wire

// [sdct_sdram_model.sv]
`default_nettype none
module sdct_sdram_model (
  input  wire logic        clk_in,   // controller clock
  input  wire logic        cl3_in,   // latency three when set
  input  wire logic [3:0]  cmd_in,   // select and strobes
  input  wire logic [1:0]  mask_in,  // byte masks
  input  wire logic [14:0] addr_in,  // bank and address
  input  wire logic [15:0] wdata_in, // data from controller
  input  wire logic        oe_in,    // controller drives data
  output logic      [15:0] dq_out    // data to controller
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [logic [23:0]];
  logic [12:0] row_q [4] = '{default: 13'h0000};
  logic [15:0] rd_q = 16'h0000;
  int          age = 99;
  wire  [23:0] key = {addr_in[14:13], row_q[addr_in[14:13]], addr_in[8:0]};
  // outside the data window the pins show the inverse, so stale data never looks valid
  assign dq_out = (age + 1 >= (cl3_in ? 3 : 2) && age < 12) ? rd_q : ~rd_q;
  always @(posedge clk_in) begin
    logic [15:0] w;
    w = mem.exists(key) ? mem[key] : 16'h0000;
    age <= age + 1;
    case (cmd_in)
      sdct_pkg::CMD_ACTIVE: row_q[addr_in[14:13]] <= addr_in[12:0];
      sdct_pkg::CMD_WRITE: begin
        for (int b = 0; b < 2; b++) if (!mask_in[b] && oe_in) w[b*8+:8] = wdata_in[b*8+:8];
        mem[key] = w;
      end
      sdct_pkg::CMD_READ: begin
        rd_q <= w;
        age <= 0;
      end
      default: ;
    endcase
  end
endmodule
`default_nettype wire

// [sdram_command_timing_ctrl_bench.sv]
`default_nettype none
module sdram_command_timing_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0, rst_n_in = 1'b0, ret_clock_in = 1'b0, stall_q = 1'b0;
  logic        req_valid_in = 1'b0, req_write_in = 1'b0, rd_ready_in = 1'b0;
  logic        cas_latency_field_in = 1'b0;
  logic [1:0]  req_bank_in = 2'h0, req_mask_in = 2'h0, rcd_field_in = 2'h0;
  logic [12:0] req_row_in = 13'h0000;
  logic [8:0]  req_col_in = 9'h000;
  logic [15:0] req_wdata_in = 16'h0000;
  logic [7:0]  lfsr_q = 8'h24;
  logic        req_ready_out, rd_valid_out, init_done_out, fclk, dq_oe_out;
  logic        cs_n, ras_n, cas_n, we_n;
  logic [1:0]  mask;
  logic [14:0] addr_out;
  logic [15:0] rd_data_out, dq_in, dq_out;
  logic [15:0] shadow [logic [23:0]];
  logic [15:0] expq [$];
  int          mismatches = 0;
  int          tests_run = 0;
  sdct_ctrl #(.REFI_CYC(100)) u_sdct_ctrl (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .req_valid_in(req_valid_in), .req_ready_out(req_ready_out), .req_write_in(req_write_in),
    .req_bank_in(req_bank_in), .req_row_in(req_row_in), .req_col_in(req_col_in),
    .req_wdata_in(req_wdata_in), .req_mask_in(req_mask_in), .rcd_field_in(rcd_field_in),
    .cas_latency_field_in(cas_latency_field_in), .mode_opcode_in(13'h0020),
    .ext_opcode_in(13'h0000), .rd_valid_out(rd_valid_out), .rd_ready_in(rd_ready_in),
    .rd_data_out(rd_data_out), .init_done_out(init_done_out),
    .forwarded_out_clock_out(fclk), .ret_clock_in(ret_clock_in),
    .mem_chip_select_n_out(cs_n), .row_strobe_n_out(ras_n), .column_strobe_n_out(cas_n),
    .write_enable_n_out(we_n), .byte_lane_mask_out(mask), .addr_out(addr_out),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_out(dq_oe_out));
  sdct_sdram_model u_sdct_sdram_model (.clk_in(clk_in), .cl3_in(cas_latency_field_in),
    .cmd_in({cs_n, ras_n, cas_n, we_n}), .mask_in(mask), .addr_in(addr_out),
    .wdata_in(dq_out), .oe_in(dq_oe_out), .dq_out(dq_in));
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  always #5 clk_in = ~clk_in;
  // returned clock runs free and deliberately off phase from clk_in
  initial begin
    #3;
    forever #40 ret_clock_in = ~ret_clock_in;
  end
  always @(posedge clk_in) begin
    lfsr_q <= lfsr_next(lfsr_q);
    rd_ready_in <= !stall_q && lfsr_q[0];
  end
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_word({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic give_up();
    mismatches++;
    report_and_stop();
  endtask
  // sampled at the falling edge, a whole half cycle after the handshake settles
  always @(negedge clk_in) begin
    if (rd_valid_out === 1'b1 && rd_ready_in === 1'b1)
      check_word(rd_data_out, expq.size() ? expq.pop_front() : 16'hXXXX);
  end
  task automatic start_up();
    int n;
    n = 0;
    do begin @(negedge clk_in); n++; end while (init_done_out !== 1'b1 && n < 300);
    if (n >= 300) give_up();
  endtask
  task automatic drain();
    int n;
    n = 0;
    do begin @(negedge clk_in); n++; end while (expq.size() != 0 && n < 500);
    if (n >= 500) give_up();
    repeat (4) @(negedge clk_in);
  endtask
  // hold > 0 expects the request to stand refused that many cycles, then lifts the stall
  task automatic access(input logic wr, input logic [23:0] k, input logic [15:0] wd,
                        input logic [1:0] mk, input int hold);
    int n;
    logic seen;
    logic [15:0] w;
    @(posedge clk_in);
    req_write_in <= wr;
    {req_bank_in, req_row_in, req_col_in} <= k;
    req_wdata_in <= wd;
    req_mask_in <= mk;
    req_valid_in <= 1'b1;
    seen = 1'b0;
    repeat (hold) begin @(negedge clk_in); seen = seen | req_ready_out; end
    if (hold > 0) begin check_bit(seen, 1'b0); stall_q = 1'b0; end
    n = 0;
    do begin @(negedge clk_in); n++; end while (req_ready_out !== 1'b1 && n < 500);
    if (n >= 500) give_up();
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    w = shadow.exists(k) ? shadow[k] : 16'h0000;
    if (wr) begin
      for (int b = 0; b < 2; b++) if (!mk[b]) w[b*8+:8] = wd[b*8+:8];
      shadow[k] = w;
    end else expq.push_back(w);
  endtask
  initial begin
    logic [7:0] r;
    logic [23:0] k;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    start_up();
    for (int i = 0; i < 8; i++) begin
      drain();
      @(posedge clk_in);
      r = lfsr_q;
      k = {r[1:0], 5'h00, r, 1'b0, r};
      rcd_field_in <= i[1:0];
      cas_latency_field_in <= i[2];
      access(1'b1, k, {r, ~r}, 2'h0, 0);
      access(1'b1, k, {~r, r}, r[3:2], 0);
      access(1'b0, k, 16'h0000, 2'h0, 0);
      access(1'b0, k ^ 24'h000001, 16'h0000, 2'h0, 0);
    end
    drain();
    stall_q = 1'b1;
    access(1'b0, k, 16'h0000, 2'h0, 0);
    access(1'b0, k, 16'h0000, 2'h0, 0);
    access(1'b0, k, 16'h0000, 2'h0, 40);
    drain();
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (3) @(negedge clk_in);
    check_bit(cs_n, 1'b1);
    check_bit(&mask, 1'b1);
    check_bit(dq_oe_out, 1'b0);
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    start_up();
    access(1'b0, k, 16'h0000, 2'h0, 0);
    drain();
    report_and_stop();
  end
endmodule
`default_nettype wire
